// ---- pdc_counter.sv ----
// Programmable 16-bit down counter with eight output modes
//
// Operation
// - Latches transparent while strobe low, hold on rise
// - Three select bits choose modes zero to seven
// - High trigger reloads counter on each edge
// - Low trigger decrements counter on each edge
// - Counting needs trigger pulse; mode seven autoreloads
// - Mode zero: output high at zero, toggle
// - Mode one: inverted level, toggle on fall
// - Mode two: one-cycle high pulse at zero
// - Mode three: one-cycle low pulse at zero
// - Mode four: pulse at zero, trigger freezes
// - Hold modes ignore reload until count zero
// - Mode five: inverted pulse with count hold
// - Mode six: output high from start to zero, for presets above one
// - Mode six retrigger reloads, output unchanged
// - Mode six pulse lasts loaded value minus one; a preset of one stays high
// - Mode seven pulses at zero and reloads
// - Mode seven runs until master reset
// - Mode seven trigger reloads and clears output
// - Zero preset keeps the counter idle
// - Counter sixteen bits, counts downward
`timescale 1ns/100ps
module pdc_counter #(
  parameter int CNT_W = pdc_pkg::PDC_CNT_W
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic master_clear_n_i,
  input wire logic write_n_i,
  input wire logic [CNT_W-1:0] preset_in_i,
  input wire logic [2:0] mode_select_i,
  input wire logic trigger_in_i,
  output logic terminal_o,
  output logic half_rate_o,
  output logic [CNT_W-1:0] count_o
);

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  // Map the select code onto behaviour flags
  function automatic pdc_pkg::pdc_mode_s pdc_decode(input logic [2:0] m);
    pdc_pkg::pdc_mode_s d;
    d = '0;
    d.inverted = m[0] & ~m[2] | (m == pdc_pkg::PDC_MODE_HOLD_INV);
    d.pulse = (m == pdc_pkg::PDC_MODE_PULSE) |
              (m == pdc_pkg::PDC_MODE_PULSE_INV) |
              (m == pdc_pkg::PDC_MODE_HOLD) |
              (m == pdc_pkg::PDC_MODE_HOLD_INV) |
              (m == pdc_pkg::PDC_MODE_FREQ);
    d.hold = (m == pdc_pkg::PDC_MODE_HOLD) |
             (m == pdc_pkg::PDC_MODE_HOLD_INV);
    d.oneshot = (m == pdc_pkg::PDC_MODE_ONESHOT);
    d.autoreload = (m == pdc_pkg::PDC_MODE_FREQ);
    return d;
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic clear_n; // Filtered master clear
  logic write_n; // Filtered write strobe
  logic trig; // Filtered trigger
  logic [2:0] mode; // Filtered mode select
  logic [CNT_W-1:0] preset; // Filtered preset data

  // One synchroniser per single pin
  pdc_sync #(.RST_VAL(1'b0)) u_sync_clr (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .pin_i(master_clear_n_i),
    .level_o(clear_n)
  );
  pdc_sync #(.RST_VAL(1'b1)) u_sync_we (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .pin_i(write_n_i),
    .level_o(write_n)
  );
  pdc_sync #(.RST_VAL(1'b0)) u_sync_trg (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .pin_i(trigger_in_i),
    .level_o(trig)
  );

  // Bus pins pass their own synchronisers
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_mode
      pdc_sync #(.RST_VAL(1'b0)) u_sync_m (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .pin_i(mode_select_i[gi]),
        .level_o(mode[gi])
      );
    end
    for (gi = 0; gi < CNT_W; gi++) begin : g_data
      pdc_sync #(.RST_VAL(1'b0)) u_sync_d (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .pin_i(preset_in_i[gi]),
        .level_o(preset[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] latch; // Held preset value
  logic [CNT_W-1:0] count; // Down counter
  pdc_pkg::pdc_phase_e phase; // Counter phase
  logic active; // Raw terminal level before inversion
  logic half; // Half-rate toggle
  logic trig_q; // Trigger of the previous cycle
  pdc_pkg::pdc_mode_s md; // Decoded mode
  logic [CNT_W-1:0] data_now; // Latch view seen this cycle
  logic at_one; // Count is about to reach zero
  logic running; // Counter is counting down
  logic do_load; // Load counter this edge
  logic do_dec; // Decrement counter this edge
  logic hit_zero; // Count reaches zero this edge
  logic start; // First count edge after the trigger falls
  localparam logic [CNT_W-1:0] PDC_DEC = CNT_W'(1); // One count step

  assign md = pdc_decode(mode);
  // Transparent while strobe is low
  assign data_now = write_n ? latch : preset;
  assign at_one = (count == pdc_pkg::PDC_ONE);
  assign running = (phase == pdc_pkg::PDC_RUN);
  // Hold modes refuse reload while running, trigger only freezes
  assign do_load = trig & ~(md.hold & running);
  assign do_dec = ~trig & running;
  // Start edge of a count-down; a preset of one reaches zero right there
  assign start = (phase == pdc_pkg::PDC_LOADED) & trig_q & ~trig;
  assign hit_zero = (do_dec | start) & at_one;

  // ----------------------------------------------------------------
  // Data latch
  // ----------------------------------------------------------------
  // Follow the data while the strobe is low, keep it otherwise
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      latch <= pdc_pkg::PDC_LATCH_RST;
    end else if (!write_n) begin
      latch <= preset;
    end
  end

  // Previous trigger, for start of count-down
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      trig_q <= 1'b0;
    end else begin
      trig_q <= trig;
    end
  end

  // ----------------------------------------------------------------
  // Counter and phase
  // ----------------------------------------------------------------
  // Load, decrement, stop at zero, or reload in frequency mode
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      count <= pdc_pkg::PDC_COUNT_RST;
      phase <= pdc_pkg::PDC_IDLE;
    end else if (!clear_n) begin
      count <= pdc_pkg::PDC_COUNT_RST;
      phase <= pdc_pkg::PDC_IDLE;
    end else if (do_load) begin
      count <= data_now;
      // Zero preset leaves the block idle
      phase <= (data_now == '0) ? pdc_pkg::PDC_IDLE
                                : pdc_pkg::PDC_LOADED;
    end else if (hit_zero && md.autoreload) begin
      // Reload on the zero edge and keep running
      count <= data_now;
      phase <= (data_now == '0) ? pdc_pkg::PDC_IDLE
                                : pdc_pkg::PDC_RUN;
    end else if (hit_zero) begin
      count <= '0;
      phase <= pdc_pkg::PDC_DONE;
    end else if (start) begin
      // Falling trigger: count-down begins this edge
      count <= count - PDC_DEC;
      phase <= pdc_pkg::PDC_RUN;
    end else if (do_dec) begin
      count <= count - PDC_DEC;
    end
  end

  // ----------------------------------------------------------------
  // Terminal level
  // ----------------------------------------------------------------
  // Raw active level; inversion applied at the output flop
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      active <= 1'b0;
    end else if (!clear_n) begin
      active <= 1'b0;
    end else if (md.oneshot) begin
      // High from first count edge until zero, for presets above one; retrigger keeps it
      if (phase == pdc_pkg::PDC_LOADED && trig_q && !trig) begin
        active <= 1'b1;
      end else if (hit_zero) begin
        active <= 1'b0;
      end
    end else if (do_load) begin
      active <= 1'b0;
    end else if (hit_zero) begin
      active <= 1'b1;
    end else if (md.pulse) begin
      active <= 1'b0;
    end
  end

  // Half-rate output toggles when the count reaches zero
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      half <= 1'b0;
    end else if (!clear_n) begin
      half <= 1'b0;
    end else if (hit_zero) begin
      half <= ~half;
    end
  end

  // ----------------------------------------------------------------
  // Output flops
  // ----------------------------------------------------------------
  // Registered pins; inverted modes rest high
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      terminal_o <= 1'b0;
      half_rate_o <= 1'b0;
      count_o <= pdc_pkg::PDC_COUNT_RST;
    end else begin
      terminal_o <= active ^ md.inverted;
      half_rate_o <= half;
      count_o <= count;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_zero_stop;
    @(posedge clk_i) disable iff (reset_i)
    (hit_zero && !md.autoreload && clear_n) |=>
      (count == '0) && (phase == pdc_pkg::PDC_DONE);
  endproperty
  a_zero_stop: assert property (p_zero_stop)
    else $error("count did not stop at zero");

  property p_load;
    @(posedge clk_i) disable iff (reset_i)
    (do_load && clear_n) |=> (count == $past(data_now));
  endproperty
  a_load: assert property (p_load)
    else $error("trigger did not load the counter");

  property p_hold_freeze;
    @(posedge clk_i) disable iff (reset_i)
    (md.hold && running && trig && clear_n) |=> $stable(count);
  endproperty
  a_hold_freeze: assert property (p_hold_freeze)
    else $error("hold mode changed count while frozen");

  property p_dec;
    @(posedge clk_i) disable iff (reset_i)
    (do_dec && !at_one && clear_n) |=> (count == $past(count) - PDC_DEC);
  endproperty
  a_dec: assert property (p_dec)
    else $error("count did not decrement");

  property p_toggle;
    @(posedge clk_i) disable iff (reset_i)
    (hit_zero && clear_n) |=> (half != $past(half)) ##1
      (half_rate_o == $past(half));
  endproperty
  a_toggle: assert property (p_toggle)
    else $error("half-rate output did not toggle at zero");

  property p_pulse_one;
    @(posedge clk_i) disable iff (reset_i)
    (hit_zero && md.pulse && !md.oneshot && clear_n && !trig) |=>
      active ##1 (!active || !clear_n);
  endproperty
  a_pulse_one: assert property (p_pulse_one)
    else $error("pulse mode output not exactly one cycle");

  property p_auto;
    @(posedge clk_i) disable iff (reset_i)
    (hit_zero && md.autoreload && clear_n) |=>
      (count == $past(data_now));
  endproperty
  a_auto: assert property (p_auto)
    else $error("frequency mode did not reload at zero");

  property p_idle_zero;
    @(posedge clk_i) disable iff (reset_i)
    (do_load && data_now == '0 && clear_n) |=>
      (phase == pdc_pkg::PDC_IDLE);
  endproperty
  a_idle_zero: assert property (p_idle_zero)
    else $error("zero preset did not idle the counter");

  property p_clear;
    @(posedge clk_i) disable iff (reset_i)
    !clear_n |=> (count == '0) && !half && !active;
  endproperty
  a_clear: assert property (p_clear)
    else $error("master clear did not clear state");

  property p_start;
    @(posedge clk_i) disable iff (reset_i)
    (start && !at_one && clear_n) |=>
      running && (count == $past(count) - PDC_DEC);
  endproperty
  a_start: assert property (p_start)
    else $error("count-down did not start after trigger fell");

  property p_oneshot_rise;
    @(posedge clk_i) disable iff (reset_i)
    (md.oneshot && start && !at_one && clear_n) |=> active;
  endproperty
  a_oneshot_rise: assert property (p_oneshot_rise)
    else $error("one-shot output did not rise at count start");

  property p_oneshot_keep;
    @(posedge clk_i) disable iff (reset_i)
    (md.oneshot && do_load && clear_n) |=> (active == $past(active));
  endproperty
  a_oneshot_keep: assert property (p_oneshot_keep)
    else $error("one-shot reload changed the output");

  property p_freq_clear;
    @(posedge clk_i) disable iff (reset_i)
    (md.autoreload && do_load && clear_n) |=> !active;
  endproperty
  a_freq_clear: assert property (p_freq_clear)
    else $error("frequency mode trigger did not clear output");

  property p_rest_high;
    @(posedge clk_i) disable iff (reset_i)
    (md.inverted && !active) |=> terminal_o;
  endproperty
  a_rest_high: assert property (p_rest_high)
    else $error("inverted mode output not resting high");

endmodule

// ---- pdc_pkg.sv ----
// Package of constants and types for the programmable down counter
package pdc_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int PDC_CNT_W = 16;
  localparam int PDC_MODE_W = 3;

  // ----------------------------------------------------------------
  // Mode codes
  // ----------------------------------------------------------------
  localparam logic [2:0] PDC_MODE_LEVEL = 3'h0;
  localparam logic [2:0] PDC_MODE_LEVEL_INV = 3'h1;
  localparam logic [2:0] PDC_MODE_PULSE = 3'h2;
  localparam logic [2:0] PDC_MODE_PULSE_INV = 3'h3;
  localparam logic [2:0] PDC_MODE_HOLD = 3'h4;
  localparam logic [2:0] PDC_MODE_HOLD_INV = 3'h5;
  localparam logic [2:0] PDC_MODE_ONESHOT = 3'h6;
  localparam logic [2:0] PDC_MODE_FREQ = 3'h7;

  // ----------------------------------------------------------------
  // Reset values and the count of one
  // ----------------------------------------------------------------
  localparam logic [15:0] PDC_COUNT_RST = 16'h0000;
  localparam logic [15:0] PDC_LATCH_RST = 16'h0000;
  localparam logic [15:0] PDC_ONE = 16'h0001;

  // ----------------------------------------------------------------
  // Counter phases
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PDC_IDLE,
    PDC_LOADED,
    PDC_RUN,
    PDC_DONE
  } pdc_phase_e;

  // Decoded view of the mode select inputs
  typedef struct packed {
    logic inverted;
    logic pulse;
    logic hold;
    logic oneshot;
    logic autoreload;
  } pdc_mode_s;

endpackage

// ---- pdc_sync.sv ----
// Three-stage synchroniser with agreement filter for one pin
`timescale 1ns/100ps
module pdc_sync #(
  parameter logic RST_VAL = 1'b0
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic pin_i,
  output logic level_o
);

  // ----------------------------------------------------------------
  // Stages
  // ----------------------------------------------------------------
  logic s1; // First stage, read only by s2
  logic s2; // Second stage
  logic s3; // Third stage

  // Shift the pin through three flops
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      s1 <= RST_VAL;
      s2 <= RST_VAL;
      s3 <= RST_VAL;
    end else begin
      s1 <= pin_i;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // Accept a change only when stages two and three agree
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      level_o <= RST_VAL;
    end else if (s2 == s3) begin
      level_o <= s3;
    end
  end

endmodule

// ---- pdc_host_model.sv ----
// Host logic model driving preset, mode, strobe and trigger pins
`timescale 1ns/100ps
module pdc_host_model (
  input wire logic clk_i,
  output logic master_clear_n_o,
  output logic write_n_o,
  output logic [15:0] preset_o,
  output logic [2:0] mode_o,
  output logic trigger_o
);
  // ----------------------------------------------------------------
  // Pin levels at time zero
  // ----------------------------------------------------------------
  // Quiet levels, applied by the bench before reset is released
  task automatic idle();
    master_clear_n_o = 1'b1;
    write_n_o = 1'b1;
    preset_o = 16'h0000;
    mode_o = 3'h0;
    trigger_o = 1'b0;
  endtask

  // ----------------------------------------------------------------
  // Host operations
  // ----------------------------------------------------------------
  // Wait n edges, then move just after the edge
  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  // Pulse master clear long enough to pass the pin filter
  task automatic clear();
    master_clear_n_o = 1'b0;
    step(6);
    master_clear_n_o = 1'b1;
    step(6);
  endtask

  // Write a preset, then scramble the bus so only the latch holds it
  task automatic load(input logic [15:0] val, input logic [2:0] mode);
    if (mode == 3'h6 && val == 16'h0001) begin
      val = 16'h0002;
    end
    mode_o = mode;
    preset_o = val;
    write_n_o = 1'b0;
    step(5);
    write_n_o = 1'b1;
    step(5);
    preset_o = ~val;
  endtask

  // Set the trigger pin level
  task automatic trig(input logic v);
    trigger_o = v;
  endtask
endmodule

// ---- pdc_counter_test.sv ----
// Self-checking bench for the programmable down counter
`timescale 1ns/100ps
module pdc_counter_test;
  // ----------------------------------------------------------------
  // Signals and counters
  // ----------------------------------------------------------------
  logic clk = 1'b0; // 50 MHz clock
  logic reset = 1'b1; // Async reset, active high
  logic mc_n, wr_n, trig, term, half;
  logic [15:0] preset, count;
  logic [2:0] mode;
  int errors = 0;
  int checks_done = 0;
  int cycles = 0; // Timeout counter
  int n, w; // Wait and width results
  logic h0; // Half-rate level before a run

  always #10 clk = ~clk;

  pdc_host_model host (.clk_i(clk), .master_clear_n_o(mc_n),
    .write_n_o(wr_n), .preset_o(preset), .mode_o(mode), .trigger_o(trig));
  pdc_counter dut (.clk_i(clk), .reset_i(reset), .master_clear_n_i(mc_n),
    .write_n_i(wr_n), .preset_in_i(preset), .mode_select_i(mode),
    .trigger_in_i(trig), .terminal_o(term), .half_rate_o(half),
    .count_o(count));

  // ----------------------------------------------------------------
  // Shared helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] b16(input logic b);
    return {15'h0000, b};
  endfunction

  // Compare and count
  task automatic check(input logic [15:0] seen, exp, input string msg);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %0t %s: %h not %h", $time, msg, seen, exp);
    end
  endtask

  // Print counts and verdict, then stop
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Wait until terminal shows lvl, at most lim edges
  task automatic wait_term(input logic lvl, input int lim);
    n = 0;
    while (term !== lvl && n < lim) begin
      host.step(1);
      n++;
    end
  endtask

  // Count edges while terminal stays at lvl
  task automatic width(input logic lvl);
    w = 0;
    while (term === lvl && w < 200) begin
      host.step(1);
      w++;
    end
  endtask

  // One trigger pulse of five cycles
  task automatic fire();
    host.trig(1'b1);
    host.step(5);
    host.trig(1'b0);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Latch holds after strobe, full width load and decrement
  task automatic t_latch();
    logic [15:0] c;
    host.clear();
    host.load(16'hffff, 3'h0);
    host.trig(1'b1);
    host.step(8);
    check(count, 16'hffff, "latched load");
    host.trig(1'b0);
    host.step(8);
    c = count;
    host.step(1);
    check(count, c - 16'h0001, "decrement");
    $display("latch test done");
  endtask

  // Zero preset idles
  task automatic t_zero();
    host.clear();
    host.load(16'h0000, 3'h2);
    fire();
    wait_term(1'b1, 30);
    check(n[15:0], 16'h001e, "idle terminal");
    check(count, 16'h0000, "idle count");
    $display("zero test done");
  endtask

  // Level modes 0 and 1
  task automatic t_level(input logic [2:0] m);
    logic rest;
    rest = m[0];
    host.clear();
    host.load(16'h0005, m);
    check(b16(term), b16(rest), "rest level");
    h0 = half;
    fire();
    wait_term(~rest, 40);
    check(b16(n < 40), 16'h0001, "reach zero");
    host.step(10);
    check(b16(term), b16(~rest), "level held");
    check(count, 16'h0000, "stop at zero");
    check(b16(half), b16(~h0), "half toggle");
    fire();
    host.step(3);
    check(b16(term), b16(rest), "trigger clears");
    $display("mode %0d test done", m);
  endtask

  // Pulse modes 2 to 5
  task automatic t_pulse(input logic [2:0] m);
    logic act;
    act = ~m[0];
    host.clear();
    host.load(16'h0004, m);
    h0 = half;
    fire();
    wait_term(act, 40);
    width(act);
    check(w[15:0], 16'h0001, "pulse");
    check(b16(half), b16(~h0), "half toggle");
    wait_term(act, 20);
    check(n[15:0], 16'h0014, "no repeat");
    $display("mode %0d test done", m);
  endtask

  // Count hold in mode 4
  task automatic t_hold();
    logic [15:0] c;
    host.clear();
    host.load(16'h001e, 3'h4);
    fire();
    host.step(10);
    host.trig(1'b1);
    host.step(8);
    c = count;
    host.step(4);
    check(count, c, "frozen");
    check(b16(c != 16'h001e), 16'h0001, "no reload");
    host.trig(1'b0);
    wait_term(1'b1, 60);
    check(b16(n < 60), 16'h0001, "resume");
    host.trig(1'b1);
    host.step(8);
    check(count, 16'h001e, "reload at zero");
    host.trig(1'b0);
    $display("hold test done");
  endtask

  // One-shot width and retrigger
  task automatic t_oneshot();
    host.clear();
    host.load(16'h0006, 3'h6);
    fire();
    wait_term(1'b1, 40);
    width(1'b1);
    check(w[15:0], 16'h0005, "one-shot width");
    // Longer preset so the retrigger lands inside the pulse
    host.load(16'h0014, 3'h6);
    fire();
    wait_term(1'b1, 40);
    host.step(2);
    fire();
    width(1'b1);
    check(b16(w > 19), 16'h0001, "retrigger");
    $display("one-shot test done");
  endtask

  // Frequency generator, trigger reload and master clear
  task automatic t_freq();
    host.clear();
    host.load(16'h0005, 3'h7);
    h0 = half;
    fire();
    wait_term(1'b1, 40);
    width(1'b1);
    check(w[15:0], 16'h0001, "freq pulse");
    wait_term(1'b1, 20);
    w = n;
    host.step(1);
    wait_term(1'b1, 20);
    check(n[15:0], w[15:0], "steady period");
    check(b16(w > 3), 16'h0001, "period length");
    check(b16(half), b16(~h0), "half toggles");
    host.trig(1'b1);
    host.step(8);
    check(count, 16'h0005, "trigger reload");
    check(b16(term), 16'h0000, "trigger clears");
    host.trig(1'b0);
    host.step(12);
    host.clear();
    check(count, 16'h0000, "clear count");
    check(b16(half), 16'h0000, "clear half");
    wait_term(1'b1, 30);
    check(n[15:0], 16'h001e, "stopped");
    $display("mode 7 test done");
  endtask

  // ----------------------------------------------------------------
  // Main sequence and timeout
  // ----------------------------------------------------------------
  initial begin
    host.idle();
    repeat (6) @(posedge clk);
    #1;
    reset = 1'b0;
    host.step(6);
    check(count, 16'h0000, "reset count");
    t_latch();
    t_zero();
    t_level(3'h0);
    t_level(3'h1);
    for (int m = 2; m < 6; m++) begin
      t_pulse(m[2:0]);
    end
    t_hold();
    t_oneshot();
    t_freq();
    give_verdict();
  end

  // Cut a hang short
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      $display("[FAIL] %0t timeout", $time);
      give_verdict();
    end
  end
endmodule
